// ==== src/tcp_defines.svh ====
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH

// Byte addresses of the three registers.
`define TCP_ADDR_SRC_SEL    16'hff1b
`define TCP_ADDR_LVL_LOW    16'hff21
`define TCP_ADDR_LVL_HIGH   16'hff2a

// Writable bit masks of each register.
`define TCP_MASK_SRC_SEL    8'h0f
`define TCP_MASK_LVL_LOW    8'h3f
`define TCP_MASK_LVL_HIGH   8'h0f

// Reset values.
`define TCP_RST_SRC_SEL     8'h00
`define TCP_RST_LVL_LOW     8'h00
`define TCP_RST_LVL_HIGH    8'h00

// Field positions.
`define TCP_SEL_T4          0
`define TCP_SEL_T7          3
`define TCP_LVL_T32_LSB     4
`define TCP_LVL_T10_LSB     2
`define TCP_LVL_SER1_LSB    0
`define TCP_LVL_T76_LSB     2
`define TCP_LVL_T54_LSB     0

`endif

// ==== src/tcp_pkg.sv ====
package tcp_pkg;

  // Register selected by an APB address.
  typedef enum logic [1:0] {
    TCP_REG_NONE = 2'h0,
    TCP_REG_SRC  = 2'h1,
    TCP_REG_LOW  = 2'h2,
    TCP_REG_HIGH = 2'h3
  } tcp_reg_t;

  // Four interrupt levels, binary code equals level.
  typedef enum logic [1:0] {
    TCP_LEVEL0 = 2'h0,
    TCP_LEVEL1 = 2'h1,
    TCP_LEVEL2 = 2'h2,
    TCP_LEVEL3 = 2'h3
  } tcp_level_t;

endpackage

// ==== src/tcp_regs_if.sv ====
`timescale 1ns/10ps
`default_nettype none

// Write port and stored values between the bus slave and the register store.
interface tcp_regs_if;
  logic       wr_src;
  logic       wr_low;
  logic       wr_high;
  logic [7:0] wdata;
  logic [7:0] src_sel;
  logic [7:0] lvl_low;
  logic [7:0] lvl_high;

  modport slave (output wr_src, output wr_low, output wr_high, output wdata,
                 input src_sel, input lvl_low, input lvl_high);
  modport store (input wr_src, input wr_low, input wr_high, input wdata,
                 output src_sel, output lvl_low, output lvl_high);
endinterface

`default_nettype wire

// ==== src/tcp_reg_store.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "tcp_defines.svh"

// Holds the three registers; unassigned bits are never stored.
module tcp_reg_store
  import tcp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  tcp_regs_if.store rif
);

  typedef struct packed {
    logic [7:0] src_sel;
    logic [7:0] lvl_low;
    logic [7:0] lvl_high;
  } tcp_store_t;

  tcp_store_t st;
  tcp_store_t next_st;

  // Masked writes keep reserved bits at zero.
  always_comb begin
    next_st = st;
    if (rif.wr_src) begin
      next_st.src_sel = rif.wdata & `TCP_MASK_SRC_SEL;
    end
    if (rif.wr_low) begin
      next_st.lvl_low = rif.wdata & `TCP_MASK_LVL_LOW;
    end
    if (rif.wr_high) begin
      next_st.lvl_high = rif.wdata & `TCP_MASK_LVL_HIGH;
    end
  end

  // Registers clear to their reset values.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= {`TCP_RST_SRC_SEL, `TCP_RST_LVL_LOW, `TCP_RST_LVL_HIGH};
    end else begin
      st <= next_st;
    end
  end

  assign rif.src_sel  = st.src_sel;
  assign rif.lvl_low  = st.lvl_low;
  assign rif.lvl_high = st.lvl_high;

endmodule

`default_nettype wire

// ==== src/tcp_timer_ctrl.sv ====
// Register access over APB was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "tcp_defines.svh"

module tcp_timer_ctrl
  import tcp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        timer4_src_sel,
  output var  logic        timer5_src_sel,
  output var  logic        timer6_src_sel,
  output var  logic        timer7_src_sel,
  output var  tcp_level_t  tmr32_level,
  output var  tcp_level_t  tmr10_level,
  output var  tcp_level_t  serial1_level,
  output var  tcp_level_t  tmr76_level,
  output var  tcp_level_t  tmr54_level
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Maps a byte address to the register it names.
  function automatic tcp_reg_t tcp_decode(input logic [31:0] addr);
    if (addr == {16'h0000, `TCP_ADDR_SRC_SEL}) begin
      return TCP_REG_SRC;
    end else if (addr == {16'h0000, `TCP_ADDR_LVL_LOW}) begin
      return TCP_REG_LOW;
    end else if (addr == {16'h0000, `TCP_ADDR_LVL_HIGH}) begin
      return TCP_REG_HIGH;
    end
    return TCP_REG_NONE;
  endfunction

  tcp_regs_if rif ();

  tcp_reg_store u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .rif     (rif)
  );

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  src;
    logic [5:0]  low;
    logic [3:0]  high;
  } tcp_state_t;

  tcp_state_t st;
  tcp_state_t next_st;
  tcp_reg_t   sel_reg;
  logic       access;

  assign sel_reg = tcp_decode(paddr);
  assign access  = psel && penable && !st.pready;

  // Write strobes fire in the first access cycle, so the store takes the word on the edge
  // that raises pready; the field outputs follow one edge later.
  assign rif.wr_src  = access && pwrite && (sel_reg == TCP_REG_SRC);
  assign rif.wr_low  = access && pwrite && (sel_reg == TCP_REG_LOW);
  assign rif.wr_high = access && pwrite && (sel_reg == TCP_REG_HIGH);
  assign rif.wdata   = pwdata[7:0];

  // One wait state per access; read data and error register with pready.
  always_comb begin
    next_st         = st;
    next_st.pready  = access;
    next_st.pslverr = access && (sel_reg == TCP_REG_NONE);
    next_st.prdata  = 32'h0000_0000;
    if (access && !pwrite) begin
      case (sel_reg)
        TCP_REG_SRC:  next_st.prdata = {24'h00_0000, rif.src_sel};
        TCP_REG_LOW:  next_st.prdata = {24'h00_0000, rif.lvl_low};
        TCP_REG_HIGH: next_st.prdata = {24'h00_0000, rif.lvl_high};
        default:      next_st.prdata = 32'h0000_0000;
      endcase
    end
    next_st.src  = rif.src_sel[3:0];
    next_st.low  = rif.lvl_low[5:0];
    next_st.high = rif.lvl_high[3:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Output copies trail the stored registers by one cycle.
  assign prdata  = st.prdata;
  assign pready  = st.pready;
  assign pslverr = st.pslverr;
  assign timer4_src_sel = st.src[`TCP_SEL_T4];
  assign timer5_src_sel = st.src[1];
  assign timer6_src_sel = st.src[2];
  assign timer7_src_sel = st.src[`TCP_SEL_T7];
  assign tmr32_level   = tcp_level_t'(st.low[`TCP_LVL_T32_LSB +: 2]);
  assign tmr10_level   = tcp_level_t'(st.low[`TCP_LVL_T10_LSB +: 2]);
  assign serial1_level = tcp_level_t'(st.low[`TCP_LVL_SER1_LSB +: 2]);
  assign tmr76_level   = tcp_level_t'(st.high[`TCP_LVL_T76_LSB +: 2]);
  assign tmr54_level   = tcp_level_t'(st.high[`TCP_LVL_T54_LSB +: 2]);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  sequence wr_seq(logic [31:0] a);
    psel && !penable && pwrite && paddr == a ##1 access && pwrite && paddr == a;
  endsequence

  chk_src_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_seq({16'h0000, `TCP_ADDR_SRC_SEL}) |=> ##1 st.src == $past(pwdata[3:0], 2))
    else $error("source select not updated by write");
  chk_src_reset: assert property (@(posedge pclk) $rose(presetn) |-> st.src == 4'h0)
    else $error("source select not clear after reset");
  chk_t32_level: assert property (@(posedge pclk) disable iff (!presetn)
    wr_seq({16'h0000, `TCP_ADDR_LVL_LOW}) |=> ##1 tmr32_level == $past(pwdata[5:4], 2))
    else $error("timer 3/2 level wrong");
  chk_t10_level: assert property (@(posedge pclk) disable iff (!presetn)
    wr_seq({16'h0000, `TCP_ADDR_LVL_LOW}) |=> ##1 tmr10_level == $past(pwdata[3:2], 2))
    else $error("timer 1/0 level wrong");
  chk_ser1_level: assert property (@(posedge pclk) disable iff (!presetn)
    wr_seq({16'h0000, `TCP_ADDR_LVL_LOW}) |=> ##1 serial1_level == $past(pwdata[1:0], 2))
    else $error("serial 1 level wrong");
  chk_t76_level: assert property (@(posedge pclk) disable iff (!presetn)
    wr_seq({16'h0000, `TCP_ADDR_LVL_HIGH}) |=> ##1 tmr76_level == $past(pwdata[3:2], 2))
    else $error("timer 7/6 level wrong");
  chk_t54_level: assert property (@(posedge pclk) disable iff (!presetn)
    wr_seq({16'h0000, `TCP_ADDR_LVL_HIGH}) |=> ##1 tmr54_level == $past(pwdata[1:0], 2))
    else $error("timer 5/4 level wrong");
  chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[31:8] == 24'h00_0000 && !(prdata[7:6] != 2'h0)
      && (rif.src_sel[7:4] == 4'h0) && (rif.lvl_high[7:4] == 4'h0))
    else $error("reserved bits not zero");
  chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

endmodule

`default_nettype wire

// ==== sim/tcp_timer_ctrl_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "tcp_defines.svh"

module tcp_timer_ctrl_bench
  import tcp_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        timer4_src_sel, timer5_src_sel, timer6_src_sel, timer7_src_sel;
  tcp_level_t  tmr32_level, tmr10_level, serial1_level, tmr76_level, tmr54_level;
  logic [7:0]  m_src = 8'h00, m_lo = 8'h00, m_hi = 8'h00;
  logic [31:0] addrs [4] = '{32'hff1b, 32'hff21, 32'hff2a, 32'h0001ff21};
  int          bad_count = 0;
  int          comparisons = 0;
  int          seed = 76;

  // The clock toggles every 20 ns, a period of 40 ns.
  always #20 pclk = ~pclk;

  tcp_timer_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer4_src_sel(timer4_src_sel), .timer5_src_sel(timer5_src_sel),
    .timer6_src_sel(timer6_src_sel), .timer7_src_sel(timer7_src_sel),
    .tmr32_level(tmr32_level), .tmr10_level(tmr10_level), .serial1_level(serial1_level),
    .tmr76_level(tmr76_level), .tmr54_level(tmr54_level));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // A hang costs a mismatch and ends the run.
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    end_of_test();
  end

  // ----------------------------------------
  // Bus master and expectations
  // ----------------------------------------
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for the slave as long as it takes; only the watchdog ends a hang.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Updates the expected copy; unassigned bits and unmapped places keep nothing.
  function automatic logic [31:0] model(input logic [31:0] a, input logic w,
                                        input logic [31:0] d);
    case (a)
      `TCP_ADDR_SRC_SEL: begin if (w) m_src = d[7:0] & 8'h0f; return {24'h0, m_src}; end
      `TCP_ADDR_LVL_LOW: begin if (w) m_lo = d[7:0] & 8'h3f; return {24'h0, m_lo}; end
      `TCP_ADDR_LVL_HIGH: begin if (w) m_hi = d[7:0] & 8'h0f; return {24'h0, m_hi}; end
      default: return 32'h0;
    endcase
  endfunction

  // Writes unless w is low, reads back and compares the read word, the error flag and all
  // fields; with w low it only reads, so reset values are seen without being written.
  task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, input logic w = 1'b1);
    logic [31:0] r, x;
    logic [3:0]  sel;
    logic        e, bad;
    bad = (a != `TCP_ADDR_SRC_SEL && a != `TCP_ADDR_LVL_LOW && a != `TCP_ADDR_LVL_HIGH);
    x = model(a, w, d);
    if (w) begin
      apb(1'b1, a, d, r, e);
      chk({31'h0, e}, {31'h0, bad});
    end
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, bad});
    sel = {timer7_src_sel, timer6_src_sel, timer5_src_sel, timer4_src_sel};
    chk({28'h0, sel}, {24'h0, m_src});
    chk({26'h0, tmr32_level, tmr10_level, serial1_level}, {24'h0, m_lo});
    chk({28'h0, tmr76_level, tmr54_level}, {24'h0, m_hi});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values read back as zero with every field at level 0.
    for (int i = 0; i < 4; i++) wr_rd(addrs[i], 32'h0, 1'b0);
    // Every level code in every field, then all ones into reserved bits.
    for (int c = 0; c < 4; c++) begin
      wr_rd(32'hff21, {26'h0, 2'(c), 2'(c), 2'(c)});
      wr_rd(32'hff2a, {28'h0, 2'(c), 2'(c)});
      wr_rd(32'hff1b, {28'h0, 2'(c), 2'(3 - c)});
    end
    for (int i = 0; i < 4; i++) wr_rd(addrs[i], 32'hffffffff);
    wr_rd(32'hff20, 32'h5);
    // Random traffic over mapped and unmapped places.
    for (int i = 0; i < 40; i++) wr_rd(addrs[$unsigned($random(seed)) % 4], $random(seed));
    // A second reset in mid-run clears everything again, from all fields set.
    for (int i = 0; i < 3; i++) wr_rd(addrs[i], 32'hffffffff);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    m_src = 8'h0; m_lo = 8'h0; m_hi = 8'h0;
    for (int i = 0; i < 3; i++) wr_rd(addrs[i], 32'h0, 1'b0);
    end_of_test();
  end
endmodule

`default_nettype wire
